// *** include/adc_readout_pkg.sv ***
// Constants and carrier types for the converter readout controller.
// Assumes a 20 MHz system clock and a converter that shifts MSB first.
`default_nettype none
package adc_readout_pkg;

  // Word and frame geometry
  localparam int unsigned WORD_BITS     = 16;  // Conversion word width
  localparam int unsigned FRAME_CLOCKS  = 17;  // Least shift clocks per readout
  localparam int unsigned BYTE_BITS     = 8;   // Byte-wide split transfer
  // Timing
  localparam int unsigned CLK_PERIOD_NS = 50;  // System clock period
  localparam int unsigned SCLK_HALF_NS  = 200; // Half period of the driven shift clock
  localparam int unsigned SCLK_HALF_CYC =
    (SCLK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned START_LOW_NS  = 100; // Conversion start pulse width
  localparam int unsigned START_LOW_CYC =
    (START_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Reset values
  localparam logic [15:0] RESULT_RST    = 16'h0000;

  // Readout timing choice
  typedef enum logic {
    READ_AFTER_CONVERSION,   // Read once busy rises, result of this conversion; with clock_master only, else read after busy falls
    READ_DURING_CONVERSION   // Read after busy falls, previous result
  } read_window_t;

  // User command
  typedef struct packed {
    logic         clock_master;  // High: controller drives the shift clock
    logic         byte_split;    // Two 8-bit transfers instead of one
    read_window_t window;        // When to read against busy
  } readout_cmd_t;

  // Result towards the user
  typedef struct packed {
    logic [15:0] word;      // Conversion word, MSB first on the link
    logic        chain_bit; // Level seen on the 17th clock
  } readout_result_t;

endpackage
`default_nettype wire

// *** rtl/adc_readout_ctrl.sv ***
// Host-side controller that starts conversions and reads the serial result.
// Assumes the converter's busy, data and shift clock pins arrive asynchronously.
//
// Functional notes
// - Master role: host select follows busy; o_clock_select is held low here instead
// - Master role: host is sole 16-bit slave
// - Master role: clock idles low, either edge
// - Start pulse from trigger or host
// - Slave role: host samples on falling edge
// - Slave role: at least 17 clocks
// - During-conversion read finishes before busy rises
// - Preferred: read after busy rises
// - Byte hosts: two 8-bit slave transfers
// - Keep converter inputs low until ready
// - Latch parallel outputs on busy bus
`timescale 1ns/1ps
`default_nettype none
module adc_readout_ctrl
  import adc_readout_pkg::*;
#(
  parameter int unsigned WORD_W = WORD_BITS  // Result width
) (
  input  wire logic            i_clk,          // System clock, 20 MHz
  input  wire logic            i_rstn,         // Synchronous reset, active low
  input  wire logic            i_supply_ok,    // Interface supply settled
  input  wire logic            i_start,        // Request one conversion and readout
  input  wire readout_cmd_t    i_cmd,          // Mode, sampled with i_start
  input  wire logic            i_ext_trigger,  // External conversion trigger
  input  wire logic            i_busy,         // Converter busy pin
  input  wire logic            i_serial_result_out, // Converter data pin
  input  wire logic            i_result_shift_clock, // Shift clock from converter
  output logic                 o_clock_select, // Low: converter is link master
  output logic                 o_conversion_start_input_n, // Start, active low
  output logic                 o_result_shift_clock, // Shift clock we drive
  output logic                 o_chain_in,     // Chain input, held low
  output logic                 o_ready,        // Idle, can accept i_start
  output logic                 o_valid,        // One-cycle result pulse
  output readout_result_t      o_result        // Captured result
);

  typedef enum logic [2:0] {
    ST_IDLE,     // Waiting for a request
    ST_START,    // Start pulse low
    ST_WAIT_LO,  // Wait for busy to fall
    ST_WAIT_HI,  // Wait for busy to rise
    ST_SHIFT,    // Clocking bits
    ST_GAP,      // Pause between byte transfers
    ST_DONE      // Deliver result
  } state_t;

  state_t          state_q;      // Sequencer state
  readout_cmd_t    cmd_q;        // Latched command
  logic [4:0]      bit_cnt_q;    // Clocks seen or given in this frame
  logic [2:0]      div_cnt_q;    // Half period divider
  logic [2:0]      pulse_cnt_q;  // Start pulse width counter
  logic [WORD_W:0] shift_q;      // Word plus chain bit
  logic            sclk_prev_q;  // Last filtered shift clock
  logic            busy_prev_q;  // Last filtered busy
  logic            trig_prev_q;  // Last external trigger
  logic            fall_dly_q;   // Our clock fell one cycle ago
  logic [2:0]      pins;         // Filtered busy, data, clock
  logic            busy_s;
  logic            data_s;
  logic            sclk_s;
  logic            half_tick;    // Divider enable
  logic            fall_edge;    // Capture edge of the shift clock
  logic            trig_rise;
  logic [4:0]      frame_end;    // Clock count that ends the current transfer

  // All three link pins come from outside our clock domain
  pin_sync3 #(.WIDTH(3)) u_sync (
    .i_clk   (i_clk),
    .i_rstn  (i_rstn),
    .i_pin   ({i_busy, i_serial_result_out, i_result_shift_clock}),
    .o_level (pins)
  );
  assign busy_s = pins[2];
  assign data_s = pins[1];
  assign sclk_s = pins[0];

  assign half_tick = (div_cnt_q == 3'(SCLK_HALF_CYC - 1));
  assign trig_rise = i_ext_trigger && !trig_prev_q;

  // First byte is 8 clocks; second byte or whole word runs to 17
  always_comb begin
    if (cmd_q.byte_split && bit_cnt_q < 5'(BYTE_BITS)) begin
      frame_end = 5'(BYTE_BITS);
    end else begin
      frame_end = 5'(FRAME_CLOCKS);
    end
  end

  // Falling edge of whichever clock runs the link
  always_comb begin
    if (cmd_q.clock_master) begin
      fall_edge = fall_dly_q;
    end else begin
      fall_edge = sclk_prev_q && !sclk_s;
    end
  end

  // Edge history
  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      sclk_prev_q <= 1'b0;
      busy_prev_q <= 1'b0;
      trig_prev_q <= 1'b0;
    end else begin
      sclk_prev_q <= sclk_s;
      busy_prev_q <= busy_s;
      trig_prev_q <= i_ext_trigger;
    end
  end

  // Data launched on our rise needs the full synchroniser delay, so the
  // capture waits one cycle past our fall; data must settle within a cycle
  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      fall_dly_q <= 1'b0;
    end else begin
      fall_dly_q <= state_q == ST_SHIFT && cmd_q.clock_master && half_tick
                    && o_result_shift_clock;
    end
  end

  // Sequencer
  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      state_q <= ST_IDLE;
      cmd_q   <= '0;
    end else begin
      unique case (state_q)
        ST_IDLE: begin
          // Inputs stay low until the supply is steady
          if (i_supply_ok && (i_start || trig_rise)) begin
            cmd_q   <= i_cmd;
            state_q <= ST_START;
          end
        end
        ST_START: begin
          if (pulse_cnt_q == 3'(START_LOW_CYC - 1)) begin
            state_q <= ST_WAIT_LO;
          end
        end
        ST_WAIT_LO: begin
          // Busy falling marks conversion start; master role shifts now
          if (busy_prev_q && !busy_s) begin
            if (!cmd_q.clock_master || cmd_q.window == READ_DURING_CONVERSION) begin
              state_q <= ST_SHIFT;
            end else begin
              state_q <= ST_WAIT_HI;
            end
          end
        end
        ST_WAIT_HI: begin
          // Clock stays still through conversion
          if (!busy_prev_q && busy_s) begin
            state_q <= ST_SHIFT;
          end
        end
        ST_SHIFT: begin
          if (fall_edge && bit_cnt_q + 5'd1 == frame_end) begin
            state_q <= (frame_end == 5'(BYTE_BITS)) ? ST_GAP : ST_DONE;
          end
        end
        ST_GAP: begin
          if (half_tick) begin
            state_q <= ST_SHIFT;
          end
        end
        ST_DONE: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  // Start pulse width
  always_ff @(posedge i_clk) begin
    if (!i_rstn || state_q != ST_START) begin
      pulse_cnt_q <= '0;
    end else begin
      pulse_cnt_q <= pulse_cnt_q + 3'd1;
    end
  end

  // Shift clock divider, runs in ST_SHIFT and ST_GAP in either role
  always_ff @(posedge i_clk) begin
    if (!i_rstn || !(state_q == ST_SHIFT || state_q == ST_GAP) || half_tick) begin
      div_cnt_q <= '0;
    end else begin
      div_cnt_q <= div_cnt_q + 3'd1;
    end
  end

  // Driven shift clock: idles low, rises to launch, falls to capture
  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      o_result_shift_clock <= 1'b0;
    end else if (state_q == ST_SHIFT && cmd_q.clock_master && half_tick) begin
      o_result_shift_clock <= !o_result_shift_clock;
    end else if (state_q != ST_SHIFT) begin
      o_result_shift_clock <= 1'b0;
    end
  end

  // Bit capture on falling edges, MSB first; 17th is the chain bit
  always_ff @(posedge i_clk) begin
    if (!i_rstn || state_q == ST_IDLE) begin
      bit_cnt_q <= '0;
      shift_q   <= '0;
    end else if (state_q == ST_SHIFT && fall_edge) begin
      bit_cnt_q <= bit_cnt_q + 5'd1;
      shift_q   <= {shift_q[WORD_W-1:0], data_s};
    end
  end

  // Result register doubles as the parallel-bus latch
  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      o_result <= '{word: RESULT_RST, chain_bit: 1'b0};
      o_valid  <= 1'b0;
    end else begin
      o_valid <= (state_q == ST_DONE);
      if (state_q == ST_DONE) begin
        o_result.word      <= shift_q[WORD_W:1];
        o_result.chain_bit <= shift_q[0];
      end
    end
  end

  // Pin outputs; all low until the supply settles
  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      o_clock_select             <= 1'b0;
      o_conversion_start_input_n <= 1'b0;
      o_chain_in                 <= 1'b0;
      o_ready                    <= 1'b0;
    end else begin
      o_clock_select             <= i_supply_ok && cmd_q.clock_master;
      o_conversion_start_input_n <= i_supply_ok && state_q != ST_START;
      o_chain_in                 <= 1'b0;
      o_ready                    <= i_supply_ok && state_q == ST_IDLE;
    end
  end

endmodule
`default_nettype wire

// *** rtl/pin_sync3.sv ***
// Three-flop synchroniser with agreement filter for link inputs.
// Assumes inputs are asynchronous to i_clk.
`timescale 1ns/1ps
`default_nettype none
module pin_sync3 #(
  parameter int unsigned WIDTH = 1  // Number of pins
) (
  input  wire logic             i_clk,   // System clock
  input  wire logic             i_rstn,  // Synchronous reset, active low
  input  wire logic [WIDTH-1:0] i_pin,   // Raw pins
  output logic      [WIDTH-1:0] o_level  // Filtered level
);
  logic [WIDTH-1:0] s1_q;  // First stage, read only by second
  logic [WIDTH-1:0] s2_q;  // Second stage
  logic [WIDTH-1:0] s3_q;  // Third stage

  // Shift chain
  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
    end else begin
      s1_q <= i_pin;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // A change counts only once stages two and three agree
  genvar g;
  generate
    for (g = 0; g < WIDTH; g++) begin : g_bit
      always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
          o_level[g] <= 1'b0;
        end else if (s2_q[g] == s3_q[g]) begin
          o_level[g] <= s3_q[g];
        end
      end
    end
  endgenerate
endmodule
`default_nettype wire

// *** verification/adc_conversion_start_input_model.sv ***
// Behavioural converter: busy flag, serial word and chain bit.
// Assumes the host drives start, select, shift clock and chain pins.
`timescale 1ns/1ps
`default_nettype none
module adc_converter_model #(
  parameter int CONVERSION_NS = 10000 // Conversion time
) (
  input  wire logic        i_start_n, // Conversion start, active low
  input  wire logic        i_select,  // High: host drives the clock
  input  wire logic        i_sclk,    // Host shift clock
  input  wire logic        i_chain,   // Chain input level
  input  wire logic [15:0] i_sample,  // Word the next conversion yields
  output logic             o_busy,    // Low while converting
  output logic             o_data,    // Serial result
  output logic             o_sclk,    // Our shift clock, idles low
  output logic             o_fault    // Conversion cut into by a short read
);
  logic [15:0] word_q = 16'h0000; // Last finished word
  logic [15:0] snap;              // Sample taken at start
  int          idx = 99;          // Bit position in the frame
  int          hits = 0;          // Host clocks during conversion
  initial begin
    o_busy = 1'b1;
    o_data = 1'b0;
    o_sclk = 1'b0;
    o_fault = 1'b0;
  end
  // Past the chain bit the line is released: show the inverse
  function automatic logic bit_at(int i);
    return i < 16 ? word_q[15-i] : (i == 16 ? i_chain : !o_data);
  endfunction
  // One conversion; in master role our clock shifts the old word
  always @(negedge i_start_n) begin
    if (o_busy) begin
      snap = i_sample;
      idx = 0;
      hits = 0;
      #40 o_busy = 1'b0;
      repeat (17) begin
        if (!i_select) begin
          o_data = bit_at(idx);
          idx++;
        end
        #20 o_sclk = !i_select;
        #200 o_sclk = 1'b0;
        #180;
      end
      if (!i_select) o_data = !o_data;
      #(CONVERSION_NS - 6840);
      o_fault = o_fault | (hits > 0 && hits < 16);
      word_q = snap;
      idx = 0;
      o_busy = 1'b1;
    end
  end
  // Slave role: next bit on each rising host clock
  always @(posedge i_sclk) begin
    if (i_select) begin
      o_data = bit_at(idx);
      idx++;
      hits = hits + int'(!o_busy);
    end
  end
endmodule
`default_nettype wire

// *** verification/adc_readout_ctrl_monitor.sv ***
// Checker on the readout controller pins.
// Bound onto adc_readout_ctrl from the bench top.
`timescale 1ns/1ps
`default_nettype none
module adc_readout_ctrl_monitor
  import adc_readout_pkg::*;
#(
  parameter int unsigned WORD_W = WORD_BITS // Result width
) (
  input wire logic            i_clk,
  input wire logic            i_rstn,
  input wire logic            i_supply_ok,
  input wire logic            i_start,
  input wire readout_cmd_t    i_cmd,
  input wire logic            i_ext_trigger,
  input wire logic            i_busy,
  input wire logic            i_serial_result_out,
  input wire logic            i_result_shift_clock,
  input wire logic            o_clock_select,
  input wire logic            o_conversion_start_input_n,
  input wire logic            o_result_shift_clock,
  input wire logic            o_chain_in,
  input wire logic            o_ready,
  input wire logic            o_valid,
  input wire readout_result_t o_result
);
  logic [4:0] rises_q; // Driven clock rises in this frame
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rstn);
  // Count rises from the start pulse on; the pulse clears it
  always_ff @(posedge i_clk) begin
    if (!i_rstn || !o_conversion_start_input_n) begin
      rises_q <= 5'h00;
    end else if ($rose(o_result_shift_clock)) begin
      rises_q <= rises_q + 5'h01;
    end
  end
  sequence s_pulse;
    !o_conversion_start_input_n ##1 o_conversion_start_input_n;
  endsequence
  sequence s_high;
    o_result_shift_clock [*4] ##1 !o_result_shift_clock;
  endsequence
  AST_CHAIN_LOW: assert property (!o_chain_in)
    else $error("chain input high");
  AST_UNPOWERED: assert property (!i_supply_ok |=> !o_conversion_start_input_n)
    else $error("start pin high without supply");
  AST_PULSE: assert property ($fell(o_conversion_start_input_n) && i_supply_ok
    |=> s_pulse) else $error("start pulse width wrong");
  AST_TAKE: assert property (o_ready && i_start && i_supply_ok
    |-> ##[1:3] !o_conversion_start_input_n) else $error("request not started");
  AST_TRIG: assert property ($rose(i_ext_trigger) && o_ready && i_supply_ok
    |-> ##[1:3] !o_conversion_start_input_n) else $error("trigger not started");
  AST_QUIET: assert property (o_ready || !o_clock_select
    |-> !o_result_shift_clock) else $error("clock not idle low");
  AST_HALF: assert property ($rose(o_result_shift_clock) |-> s_high)
    else $error("clock high half wrong");
  AST_COUNT: assert property (o_valid |-> rises_q == 5'h00 || rises_q == 5'h11)
    else $error("wrong clock count in frame");
endmodule
`default_nettype wire

// *** verification/tb_adc_readout_ctrl.sv ***
// Self-checking bench: controller against the converter model.
// Assumes adc_converter_model and the monitor are compiled before it.
`timescale 1ns/1ps
`default_nettype none
module tb_adc_readout_ctrl;
  import adc_readout_pkg::*;
  logic            clk = 1'b0;      // 20 MHz clock
  logic            rstn = 1'b0;     // Reset, active low
  logic            sup = 1'b1;      // Supply settled
  logic            start = 1'b0;    // User request
  logic            trig = 1'b0;     // External trigger
  readout_cmd_t    cmd = '0;        // Mode of the next run
  logic [15:0]     samp = 16'h0000; // Word the next conversion yields
  logic [15:0]     last = 16'h0000; // Last finished word
  logic            busy, sdat, csclk, sel, start_n, hsclk, chain, rdy, vld, fault;
  readout_result_t res;             // Result seen
  int              n_mismatch = 0;
  int              compares = 0;
  adc_readout_ctrl i_adc_readout_ctrl (
    .i_clk(clk), .i_rstn(rstn), .i_supply_ok(sup), .i_start(start), .i_cmd(cmd),
    .i_ext_trigger(trig), .i_busy(busy), .i_serial_result_out(sdat),
    .i_result_shift_clock(csclk), .o_clock_select(sel),
    .o_conversion_start_input_n(start_n), .o_result_shift_clock(hsclk),
    .o_chain_in(chain), .o_ready(rdy), .o_valid(vld), .o_result(res)
  );
  adc_converter_model i_adc_converter_model (
    .i_start_n(start_n), .i_select(sel), .i_sclk(hsclk), .i_chain(chain), .i_sample(samp),
    .o_busy(busy), .o_data(sdat), .o_sclk(csclk), .o_fault(fault)
  );
  initial begin
    forever #25 clk = ~clk;
  end
  task automatic chk(input logic [17:0] seen, input logic [17:0] exp);
    compares++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Only a slave-role read after the conversion sees the new word
  function automatic logic [16:0] expect_res(readout_cmd_t c);
    return {(c.clock_master && c.window == READ_AFTER_CONVERSION) ? samp : last, 1'b0};
  endfunction
  // One conversion and readout; waits for an idle converter first
  task automatic run(input readout_cmd_t c, input bit by_trig);
    int k;
    for (k = 0; k < 400 && !(rdy && busy); k++) @(negedge clk);
    repeat (4) @(negedge clk);
    samp = 16'($urandom);
    cmd = c;
    start = !by_trig;
    trig = by_trig;
    @(negedge clk);
    start = 1'b0;
    trig = 1'b0;
    for (k = 0; k < 2000 && !vld; k++) @(negedge clk);
    chk({vld, res}, {1'b1, expect_res(c)});
    chk({17'h0_0000, sel}, {17'h0_0000, c.clock_master});
    last = samp;
  endtask
  task automatic summarize();
    $display("mismatches %0d compares %0d", n_mismatch, compares);
    if (n_mismatch == 0 && compares > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  // Every mode once, then random modes; one run by trigger
  initial begin
    void'($urandom(32'hbcfd_d11a));
    repeat (8) @(negedge clk);
    rstn = 1'b1;
    for (int i = 0; i < 16; i++) begin
      run(readout_cmd_t'(3'(i < 8 ? i : $urandom)), i == 5);
    end
    chk({17'h0_0000, fault}, 18'h0_0000);
    // Supply drop while idle: no request taken, start held low
    sup = 1'b0;
    start = 1'b1;
    repeat (4) @(negedge clk);
    chk({16'h0000, rdy, start_n}, 18'h0_0000);
    start = 1'b0;
    summarize();
  end
  // Cut a hang short
  initial begin
    #2_000_000;
    n_mismatch++;
    summarize();
  end
endmodule
bind adc_readout_ctrl adc_readout_ctrl_monitor #(
  .WORD_W (WORD_W)
) i_adc_readout_ctrl_monitor (
  .i_clk                      (i_clk),
  .i_rstn                     (i_rstn),
  .i_supply_ok                (i_supply_ok),
  .i_start                    (i_start),
  .i_cmd                      (i_cmd),
  .i_ext_trigger              (i_ext_trigger),
  .i_busy                     (i_busy),
  .i_serial_result_out        (i_serial_result_out),
  .i_result_shift_clock       (i_result_shift_clock),
  .o_clock_select             (o_clock_select),
  .o_conversion_start_input_n (o_conversion_start_input_n),
  .o_result_shift_clock       (o_result_shift_clock),
  .o_chain_in                 (o_chain_in),
  .o_ready                    (o_ready),
  .o_valid                    (o_valid),
  .o_result                   (o_result)
);
`default_nettype wire
